/* File: core/ddrcd_pkg.sv */
// ddrcd_pkg: shared constants and types for the ddr command decoder link
// assumes nothing beyond a systemverilog compiler
package ddrcd_pkg;
    localparam int ADDR_W     = 13;
    localparam int BANK_W     = 2;
    localparam int NUM_BANKS  = 4;
    localparam int DATA_W     = 8;
    localparam int MASK_W     = 1;
    localparam int AP_BIT_X32 = 8;
    localparam int AP_BIT_X16 = 10;
    localparam int CFG_X32    = 0;
    localparam int CFG_X16    = 1;
    localparam int CFG_X8     = 2;
    localparam int ROW_W      = 13;
    localparam int COL_W      = 10;
    localparam int MODE_W     = 13;
    localparam logic [BANK_W-1:0] MRS_BASE_SEL = 2'h0;
    localparam logic [BANK_W-1:0] MRS_EXT_SEL  = 2'h1;
    // {ras_n, cas_n, we_n}
    localparam logic [2:0] ENC_NOP   = 3'h7;
    localparam logic [2:0] ENC_ACT   = 3'h3;
    localparam logic [2:0] ENC_READ  = 3'h5;
    localparam logic [2:0] ENC_WRITE = 3'h4;
    localparam logic [2:0] ENC_BST   = 3'h6;
    localparam logic [2:0] ENC_PRE   = 3'h2;
    localparam logic [2:0] ENC_REF   = 3'h1;
    localparam logic [2:0] ENC_MRS   = 3'h0;
    // host clock divider: link clock half period in mclk cycles
    localparam int LINK_HALF_DIV = 2;
    localparam int SYNC_STAGES   = 2;

    typedef enum logic [3:0] {
        DDRCD_OP_NOP,
        DDRCD_OP_ACT,
        DDRCD_OP_READ,
        DDRCD_OP_WRITE,
        DDRCD_OP_BST,
        DDRCD_OP_PRE,
        DDRCD_OP_PREALL,
        DDRCD_OP_REF,
        DDRCD_OP_MRS
    } ddrcd_op_t;

    typedef enum logic [1:0] {
        DDRCD_PWR_RUN,
        DDRCD_PWR_PRE_PD,
        DDRCD_PWR_ACT_PD,
        DDRCD_PWR_SELF_REF
    } ddrcd_pwr_t;
endpackage

/* File: core/ddrcd_link_if.sv */
// ddrcd_link_if: command pins between controller and memory device
// assumes the bench drives nothing; host makes ck
`timescale 1ns/1ps
interface ddrcd_link_if;
    logic                           ck;
    logic                           cke;
    logic                           cs_n;
    logic                           ras_n;
    logic                           cas_n;
    logic                           we_n;
    logic [ddrcd_pkg::BANK_W-1:0]   ba;
    logic [ddrcd_pkg::ADDR_W-1:0]   addr;
    logic [ddrcd_pkg::DATA_W-1:0]   wdata;
    logic [ddrcd_pkg::MASK_W-1:0]   dm;

    modport host (
        output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, wdata, dm
    );
    modport dev (
        input  ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, wdata, dm
    );
endinterface

/* File: core/ddrcd_device.sv */
// ddrcd_device: command and clock-enable decoder of the memory device
// assumes link.ck clocks all logic here; rst is asynchronous to it
`timescale 1ns/1ps
module ddrcd_device #(
    parameter int CFG       = ddrcd_pkg::CFG_X8,
    parameter int REF_CNT_W = 13
) (
    ddrcd_link_if.dev                         link,
    input  wire logic                         rst,
    output logic [ddrcd_pkg::NUM_BANKS-1:0]   bank_open,
    output logic [ddrcd_pkg::ROW_W-1:0]       open_row_last,
    output logic [1:0]                        pwr_state,
    output logic                              rd_start,
    output logic                              wr_start,
    output logic [ddrcd_pkg::COL_W-1:0]       col,
    output logic [ddrcd_pkg::BANK_W-1:0]      bank,
    output logic                              auto_pre,
    output logic                              burst_stop,
    output logic                              refresh_pulse,
    output logic [REF_CNT_W-1:0]              refresh_count,
    output logic [ddrcd_pkg::MODE_W-1:0]      mode_base,
    output logic [ddrcd_pkg::MODE_W-1:0]      mode_ext,
    output logic                              wr_beat,
    output logic [ddrcd_pkg::DATA_W-1:0]      wr_beat_data
);
    localparam int AP_BIT = (CFG == ddrcd_pkg::CFG_X32) ?
        ddrcd_pkg::AP_BIT_X32 : ddrcd_pkg::AP_BIT_X16;

    ddrcd_pkg::ddrcd_op_t  op;
    ddrcd_pkg::ddrcd_pwr_t pwr;
    logic                  cke_prev;
    logic                  ap;
    logic [ddrcd_pkg::COL_W-1:0] next_col;
    logic                  wr_active;
    logic                  all_idle;

    assign ap       = link.addr[AP_BIT];
    assign all_idle = ~|bank_open;
    assign pwr_state = pwr;

    // column field excludes the auto-precharge line
    always_comb begin
        next_col = '0;
        if (CFG == ddrcd_pkg::CFG_X32) begin
            next_col = {1'h0, link.addr[ddrcd_pkg::AP_BIT_X32 + 1],
                        link.addr[ddrcd_pkg::AP_BIT_X32-1:0]};
        end else if (CFG == ddrcd_pkg::CFG_X16) begin
            next_col = {1'h0, link.addr[8:0]};
        end else begin
            next_col = link.addr[9:0];
        end
    end

    // command decode; chip select high masks everything
    always_comb begin
        op = ddrcd_pkg::DDRCD_OP_NOP;
        if (!link.cs_n) begin
            unique case ({link.ras_n, link.cas_n, link.we_n})
                ddrcd_pkg::ENC_NOP:   op = ddrcd_pkg::DDRCD_OP_NOP;
                ddrcd_pkg::ENC_ACT:   op = ddrcd_pkg::DDRCD_OP_ACT;
                ddrcd_pkg::ENC_READ:  op = ddrcd_pkg::DDRCD_OP_READ;
                ddrcd_pkg::ENC_WRITE: op = ddrcd_pkg::DDRCD_OP_WRITE;
                ddrcd_pkg::ENC_BST:   op = ddrcd_pkg::DDRCD_OP_BST;
                ddrcd_pkg::ENC_PRE:   op = ap ? ddrcd_pkg::DDRCD_OP_PREALL
                                              : ddrcd_pkg::DDRCD_OP_PRE;
                ddrcd_pkg::ENC_REF:   op = ddrcd_pkg::DDRCD_OP_REF;
                ddrcd_pkg::ENC_MRS:   op = ddrcd_pkg::DDRCD_OP_MRS;
            endcase
        end
    end

    // clock enable history
    always_ff @(posedge link.ck or posedge rst) begin
        if (rst) begin
            cke_prev <= 1'b0;
        end else begin
            cke_prev <= link.cke;
        end
    end

    // power state from cke transitions
    always_ff @(posedge link.ck or posedge rst) begin
        if (rst) begin
            pwr <= ddrcd_pkg::DDRCD_PWR_RUN;
        end else if (cke_prev && !link.cke) begin
            if (op == ddrcd_pkg::DDRCD_OP_REF && all_idle) begin
                pwr <= ddrcd_pkg::DDRCD_PWR_SELF_REF;
            end else if (op == ddrcd_pkg::DDRCD_OP_NOP) begin
                pwr <= all_idle ? ddrcd_pkg::DDRCD_PWR_PRE_PD
                                : ddrcd_pkg::DDRCD_PWR_ACT_PD;
            end
        end else if (!cke_prev && link.cke) begin
            pwr <= ddrcd_pkg::DDRCD_PWR_RUN;
        end
    end

    // commands act only with cke high at both edges, except a refresh with cke falling (self refresh entry)
    logic cmd_ok;
    assign cmd_ok = cke_prev && link.cke;

    // per-bank open state and last opened row
    always_ff @(posedge link.ck or posedge rst) begin
        if (rst) begin
            bank_open     <= '0;
            open_row_last <= '0;
        end else if (cmd_ok) begin
            unique case (op)
                ddrcd_pkg::DDRCD_OP_ACT: begin
                    bank_open[link.ba] <= 1'b1;
                    open_row_last <= link.addr[ddrcd_pkg::ROW_W-1:0];
                end
                ddrcd_pkg::DDRCD_OP_PRE:    bank_open[link.ba] <= 1'b0;
                ddrcd_pkg::DDRCD_OP_PREALL: bank_open <= '0;
                ddrcd_pkg::DDRCD_OP_READ,
                ddrcd_pkg::DDRCD_OP_WRITE: begin
                    if (ap) begin
                        bank_open[link.ba] <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // burst start, terminate and refresh pulses
    always_ff @(posedge link.ck or posedge rst) begin
        if (rst) begin
            rd_start      <= 1'b0;
            wr_start      <= 1'b0;
            col           <= '0;
            bank          <= '0;
            auto_pre      <= 1'b0;
            burst_stop    <= 1'b0;
            refresh_pulse <= 1'b0;
        end else begin
            rd_start      <= cmd_ok && op == ddrcd_pkg::DDRCD_OP_READ;
            wr_start      <= cmd_ok && op == ddrcd_pkg::DDRCD_OP_WRITE;
            burst_stop    <= cmd_ok && op == ddrcd_pkg::DDRCD_OP_BST
                             && !auto_pre && !wr_active;
            refresh_pulse <= cmd_ok && op == ddrcd_pkg::DDRCD_OP_REF;
            if (cmd_ok && (op == ddrcd_pkg::DDRCD_OP_READ ||
                           op == ddrcd_pkg::DDRCD_OP_WRITE)) begin
                col      <= next_col;
                bank     <= link.ba;
                auto_pre <= ap;
            end
        end
    end

    // write burst window for masking beats
    always_ff @(posedge link.ck or posedge rst) begin
        if (rst) begin
            wr_active <= 1'b0;
        end else if (cmd_ok && op == ddrcd_pkg::DDRCD_OP_WRITE) begin
            wr_active <= 1'b1;
        end else if (cmd_ok && op != ddrcd_pkg::DDRCD_OP_NOP) begin
            wr_active <= 1'b0;
        end
    end

    // masked beats never reach storage
    always_ff @(posedge link.ck or posedge rst) begin
        if (rst) begin
            wr_beat      <= 1'b0;
            wr_beat_data <= '0;
        end else begin
            wr_beat <= wr_active && !link.dm[0];
            if (wr_active && !link.dm[0]) begin
                wr_beat_data <= link.wdata;
            end
        end
    end

    // internal refresh counter, address ignored
    always_ff @(posedge link.ck or posedge rst) begin
        if (rst) begin
            refresh_count <= '0;
        end else if ((cmd_ok && op == ddrcd_pkg::DDRCD_OP_REF) ||
                     (cke_prev && !link.cke &&
                      op == ddrcd_pkg::DDRCD_OP_REF)) begin
            refresh_count <= refresh_count + 1'b1;
        end
    end

    // mode registers
    always_ff @(posedge link.ck or posedge rst) begin
        if (rst) begin
            mode_base <= '0;
            mode_ext  <= '0;
        end else if (cmd_ok && op == ddrcd_pkg::DDRCD_OP_MRS) begin
            if (link.ba == ddrcd_pkg::MRS_BASE_SEL) begin
                mode_base <= link.addr;
            end else if (link.ba == ddrcd_pkg::MRS_EXT_SEL) begin
                mode_ext <= link.addr;
            end
        end
    end
endmodule

/* File: core/ddrcd_host.sv */
// ddrcd_host: controller end, drives link pins from a one-shot request
// assumes mclk domain user side; link clock made here by divider
`timescale 1ns/1ps
module ddrcd_host (
    input  wire logic                            mclk,
    input  wire logic                            rst,
    ddrcd_link_if.host                           link,
    input  wire logic                            req_valid,
    output logic                                 req_ready,
    input  wire logic [2:0]                      req_cmd,
    input  wire logic                            req_cke,
    input  wire logic [ddrcd_pkg::BANK_W-1:0]    req_ba,
    input  wire logic [ddrcd_pkg::ADDR_W-1:0]    req_addr,
    input  wire logic [ddrcd_pkg::DATA_W-1:0]    req_wdata,
    input  wire logic [ddrcd_pkg::MASK_W-1:0]    req_dm
);
    logic [1:0] div;
    logic       ck;
    logic       busy;
    logic       fall;

    // link clock divider
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div <= '0;
            ck  <= 1'b0;
        end else if (div == 2'(ddrcd_pkg::LINK_HALF_DIV - 1)) begin
            div <= '0;
            ck  <= ~ck;
        end else begin
            div <= div + 2'h1;
        end
    end
    assign link.ck = ck;
    assign fall = ck && div == 2'(ddrcd_pkg::LINK_HALF_DIV - 1);

    // pins change on link clock fall, stand one full link cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            link.cke   <= 1'b0;
            link.cs_n  <= 1'b1;
            link.ras_n <= 1'b1;
            link.cas_n <= 1'b1;
            link.we_n  <= 1'b1;
            link.ba    <= '0;
            link.addr  <= '0;
            link.wdata <= '0;
            link.dm    <= '1;
            busy       <= 1'b0;
        end else if (fall) begin
            link.cke <= busy ? req_cke : link.cke;
            if (busy) begin
                {link.ras_n, link.cas_n, link.we_n} <= req_cmd;
                link.cs_n  <= 1'b0;
                link.ba    <= req_ba;
                link.addr  <= req_addr;
                link.wdata <= req_wdata;
                link.dm    <= req_dm;
            end else begin
                link.cs_n <= 1'b1;
            end
            busy <= !busy && req_valid;
        end else if (req_valid && !busy) begin
            busy <= 1'b1;
        end
    end
    assign req_ready = !busy;
endmodule

/* File: testbench/ddrcd_monitor.sv */
// ddrcd_monitor: assertions on link pins and device outputs
// assumes x8 device config; all checks on the rising link clock
`timescale 1ns/1ps
module ddrcd_monitor (
    input wire logic        ck,
    input wire logic        rst,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [1:0]  ba,
    input wire logic [12:0] addr,
    input wire logic [3:0]  bank_open,
    input wire logic [1:0]  pwr_state,
    input wire logic        rd_start,
    input wire logic        wr_start,
    input wire logic        refresh_pulse
);
    logic       cke_q;
    logic [2:0] enc;
    logic       live;
    assign enc  = {ras_n, cas_n, we_n};
    assign live = cke & cke_q & ~cs_n;
    always_ff @(posedge ck or posedge rst) begin
        if (rst) begin
            cke_q <= 1'b0;
        end else begin
            cke_q <= cke;
        end
    end
    default clocking @(posedge ck); endclocking
    default disable iff (rst);
    property p_act;
        live && enc == ddrcd_pkg::ENC_ACT |=> bank_open[$past(ba)];
    endproperty
    a_act: assert property (p_act) else $error("bank not opened");
    property p_rd;
        live && enc == ddrcd_pkg::ENC_READ |=> rd_start;
    endproperty
    a_rd: assert property (p_rd) else $error("read not started");
    property p_wr;
        live && enc == ddrcd_pkg::ENC_WRITE |=> wr_start;
    endproperty
    a_wr: assert property (p_wr) else $error("write not started");
    property p_nop;
        cs_n || enc == ddrcd_pkg::ENC_NOP
        |=> !rd_start && !wr_start && $stable(bank_open);
    endproperty
    a_nop: assert property (p_nop) else $error("nop changed state");
    property p_pre;
        live && enc == ddrcd_pkg::ENC_PRE && !addr[10]
        |=> !bank_open[$past(ba)];
    endproperty
    a_pre: assert property (p_pre) else $error("bank not closed");
    property p_preall;
        live && enc == ddrcd_pkg::ENC_PRE && addr[10] |=> bank_open == 4'h0;
    endproperty
    a_preall: assert property (p_preall) else $error("banks open");
    property p_ref;
        live && enc == ddrcd_pkg::ENC_REF |=> refresh_pulse;
    endproperty
    a_ref: assert property (p_ref) else $error("no refresh");
    property p_pd;
        cke_q && !cke && (cs_n || enc == ddrcd_pkg::ENC_NOP)
        && bank_open == 4'h0 |=> pwr_state == ddrcd_pkg::DDRCD_PWR_PRE_PD;
    endproperty
    a_pd: assert property (p_pd) else $error("no power-down");
    property p_sr;
        cke_q && !cke && !cs_n && enc == ddrcd_pkg::ENC_REF
        && bank_open == 4'h0 |=> pwr_state == ddrcd_pkg::DDRCD_PWR_SELF_REF;
    endproperty
    a_sr: assert property (p_sr) else $error("no self refresh");
endmodule

/* File: testbench/ddr_sdram_command_decoder_tb.sv */
// ddr_sdram_command_decoder_tb: host and device joined, command tests
// assumes x8 device config; host derives the link clock from mclk
`timescale 1ns/1ps
module ddr_sdram_command_decoder_tb;
    logic        mclk      = 1'b0;
    logic        rst       = 1'b1;
    logic        req_valid = 1'b0;
    logic [2:0]  req_cmd   = 3'h7;
    logic        req_cke   = 1'b0;
    logic [1:0]  req_ba    = 2'h0;
    logic [12:0] req_addr  = 13'h0000;
    logic [7:0]  req_wdata = 8'h00;
    logic [0:0]  req_dm    = 1'h1;
    logic        req_ready, rd_start, wr_start, burst_stop;
    logic        refresh_pulse, auto_pre, wr_beat;
    logic [3:0]  bank_open;
    logic [1:0]  pwr_state, bank;
    logic [9:0]  col;
    logic [7:0]  wr_beat_data;
    logic [12:0] open_row_last, refresh_count, mode_base, mode_ext;
    logic [15:0] n_rd = 16'h0000;
    logic [15:0] n_wr = 16'h0000;
    logic [15:0] n_bst = 16'h0000;
    logic [15:0] n_ref = 16'h0000;
    int          miscompares = 0;
    int          check_count = 0;
    always #2.5 mclk = ~mclk;
    ddrcd_link_if ddrcd_link_if_i ();
    ddrcd_host ddrcd_host_i (.mclk(mclk), .rst(rst), .link(ddrcd_link_if_i),
        .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
        .req_cke(req_cke), .req_ba(req_ba), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_dm(req_dm));
    ddrcd_device ddrcd_device_i (.link(ddrcd_link_if_i), .rst(rst),
        .bank_open(bank_open), .open_row_last(open_row_last),
        .pwr_state(pwr_state), .rd_start(rd_start), .wr_start(wr_start),
        .col(col), .bank(bank), .auto_pre(auto_pre), .burst_stop(burst_stop),
        .refresh_pulse(refresh_pulse), .refresh_count(refresh_count),
        .mode_base(mode_base), .mode_ext(mode_ext), .wr_beat(wr_beat),
        .wr_beat_data(wr_beat_data));
    ddrcd_monitor ddrcd_monitor_i (.ck(ddrcd_link_if_i.ck), .rst(rst),
        .cke(ddrcd_link_if_i.cke), .cs_n(ddrcd_link_if_i.cs_n),
        .ras_n(ddrcd_link_if_i.ras_n), .cas_n(ddrcd_link_if_i.cas_n),
        .we_n(ddrcd_link_if_i.we_n), .ba(ddrcd_link_if_i.ba),
        .addr(ddrcd_link_if_i.addr), .bank_open(bank_open),
        .pwr_state(pwr_state), .rd_start(rd_start), .wr_start(wr_start),
        .refresh_pulse(refresh_pulse));
    // count one-cycle pulses at the link clock
    always @(posedge ddrcd_link_if_i.ck) begin
        n_rd  <= n_rd + {15'h0000, rd_start};
        n_wr  <= n_wr + {15'h0000, wr_start};
        n_bst <= n_bst + {15'h0000, burst_stop};
        n_ref <= n_ref + {15'h0000, refresh_pulse};
    end
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic send(logic [2:0] c, logic [1:0] b = 2'h0,
                        logic [12:0] a = 13'h0000, logic k = 1'b1,
                        logic [7:0] d = 8'h00, logic m = 1'b1);
        @(posedge mclk);
        req_valid <= 1'b1;
        req_cmd   <= c;
        req_cke   <= k;
        req_ba    <= b;
        req_addr  <= a;
        req_wdata <= d;
        req_dm    <= m;
        @(negedge mclk);
        while (!req_ready) @(negedge mclk);
        @(posedge mclk);
        req_valid <= 1'b0;
        repeat (24) @(posedge mclk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        send(ddrcd_pkg::ENC_NOP);
        send(ddrcd_pkg::ENC_NOP);
        check("pwr_state", 16'(pwr_state), 16'h0000);
        send(ddrcd_pkg::ENC_ACT, 2'h1, 13'h1ABC);
        check("bank_open", 16'(bank_open), 16'h0002);
        check("open_row_last", 16'(open_row_last), 16'h1ABC);
        send(ddrcd_pkg::ENC_READ, 2'h1, 13'h0155);
        check("n_rd", n_rd, 16'h0001);
        check("col", 16'(col), 16'h0155);
        check("bank", 16'(bank), 16'h0001);
        check("auto_pre", 16'(auto_pre), 16'h0000);
        check("bank_open", 16'(bank_open), 16'h0002);
        send(ddrcd_pkg::ENC_BST);
        check("n_bst", n_bst, 16'h0001);
        $display("test read done");
        send(ddrcd_pkg::ENC_WRITE, 2'h1, 13'h04AA);
        check("n_wr", n_wr, 16'h0001);
        check("col", 16'(col), 16'h00AA);
        check("auto_pre", 16'(auto_pre), 16'h0001);
        check("bank_open", 16'(bank_open), 16'h0000);
        send(ddrcd_pkg::ENC_NOP, 2'h0, 13'h0000, 1'b1, 8'h5A, 1'b0);
        check("wr_beat", 16'(wr_beat), 16'h0001);
        check("wr_beat_data", 16'(wr_beat_data), 16'h005A);
        send(ddrcd_pkg::ENC_NOP, 2'h0, 13'h0000, 1'b1, 8'hC3, 1'b1);
        check("wr_beat", 16'(wr_beat), 16'h0000);
        check("wr_beat_data", 16'(wr_beat_data), 16'h005A);
        send(ddrcd_pkg::ENC_BST);
        check("n_bst", n_bst, 16'h0001);
        $display("test write done");
        send(ddrcd_pkg::ENC_ACT, 2'h0);
        send(ddrcd_pkg::ENC_ACT, 2'h3);
        check("bank_open", 16'(bank_open), 16'h0009);
        send(ddrcd_pkg::ENC_PRE, 2'h3);
        check("bank_open", 16'(bank_open), 16'h0001);
        send(ddrcd_pkg::ENC_ACT, 2'h2);
        send(ddrcd_pkg::ENC_PRE, 2'h3, 13'h0400);
        check("bank_open", 16'(bank_open), 16'h0000);
        send(ddrcd_pkg::ENC_MRS, 2'h0, 13'h0123);
        send(ddrcd_pkg::ENC_MRS, 2'h1, 13'h0456);
        check("mode_base", 16'(mode_base), 16'h0123);
        check("mode_ext", 16'(mode_ext), 16'h0456);
        send(ddrcd_pkg::ENC_REF, 2'h3, 13'h1FFF);
        check("n_ref", n_ref, 16'h0001);
        check("bank_open", 16'(bank_open), 16'h0000);
        check("refresh_count", 16'(refresh_count), 16'h0001);
        $display("test bank done");
        send(ddrcd_pkg::ENC_NOP, 2'h0, 13'h0000, 1'b0);
        check("pwr_state", 16'(pwr_state), 16'h0001);
        send(ddrcd_pkg::ENC_ACT, 2'h0, 13'h0000, 1'b0);
        check("bank_open", 16'(bank_open), 16'h0000);
        send(ddrcd_pkg::ENC_NOP);
        check("pwr_state", 16'(pwr_state), 16'h0000);
        send(ddrcd_pkg::ENC_ACT, 2'h0);
        send(ddrcd_pkg::ENC_NOP, 2'h0, 13'h0000, 1'b0);
        check("pwr_state", 16'(pwr_state), 16'h0002);
        send(ddrcd_pkg::ENC_NOP);
        send(ddrcd_pkg::ENC_PRE, 2'h0, 13'h0400);
        send(ddrcd_pkg::ENC_REF, 2'h0, 13'h0000, 1'b0);
        check("pwr_state", 16'(pwr_state), 16'h0003);
        check("refresh_count", 16'(refresh_count), 16'h0002);
        send(ddrcd_pkg::ENC_NOP);
        check("pwr_state", 16'(pwr_state), 16'h0000);
        $display("test power done");
        finish_test();
    end
endmodule
